/* src/absc_pkg.sv */
package absc_pkg;

  // Chain length: comparator cells then converter cells
  localparam int ABSC_NUM_CELLS = 23;
  localparam int ABSC_DAC_W = 10;
  localparam int ABSC_DAC_MSB = 9;

  // Chain positions, cell 0 sits next to the serial input
  localparam int ABSC_POS_CMP_OFF = 0;
  localparam int ABSC_POS_CMP_RES = 1;
  localparam int ABSC_POS_CMP_MUX = 2;
  localparam int ABSC_POS_CMP_BG = 3;
  localparam int ABSC_POS_CONV_CMP = 4;
  localparam int ABSC_POS_GAIN_CLK = 5;
  localparam int ABSC_POS_PATH_EN = 6;
  localparam int ABSC_POS_BG_NEG = 7;
  localparam int ABSC_POS_CONV_PWR = 8;
  localparam int ABSC_POS_GAIN_PWR = 9;
  localparam int ABSC_POS_DAC_LO = 10;
  localparam int ABSC_POS_BYPASS = 20;
  localparam int ABSC_POS_GAIN10 = 21;
  localparam int ABSC_POS_GAIN20 = 22;

  // Update-stage reset values (recommended idle levels)
  localparam logic [ABSC_NUM_CELLS-1:0] ABSC_UPD_RESET = 23'h180001;
  localparam logic [ABSC_DAC_W-1:0] ABSC_DAC_IDLE = 10'h200;

  // Synchroniser depth for pins from the tester domain
  localparam int ABSC_SYNC_STAGES = 2;

  // Functional control bundle toward the analog front end
  typedef struct packed {
    logic comparatorOff;
    logic comparatorUsesConvMux;
    logic comparatorBandgapEn;
    logic gainStageClk;
    logic gainToComparatorPathEn;
    logic convBandgapNegEn;
    logic convPowerOn;
    logic gainStagePowerOn;
    logic [9:0] dacWord;
    logic lowChannelBypassEn;
    logic gainTenEn;
    logic gainTwentyEn;
  } absc_ctrl_s;

  // Control bundle at its idle levels, used while in reset
  localparam absc_ctrl_s ABSC_CTRL_RESET = '{comparatorOff: 1'b1,
    dacWord: ABSC_DAC_IDLE, lowChannelBypassEn: 1'b1, default: '0};

  // Observed outputs from the analog front end
  typedef struct packed {
    logic comparatorResult;
    logic convComparatorResult;
  } absc_obs_s;

  // Tester-side test port states, raw from pins
  typedef struct packed {
    logic testClk;
    logic testDataIn;
    logic captureDr;
    logic shiftDr;
    logic updateDr;
    logic extest;
  } absc_tap_s;

endpackage

/* src/absc_sync.sv */
`timescale 1ns/100ps
// Two-flop synchroniser for a bundle of levels from another domain
module absc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_synced;

  // Next values: first stage only feeds the second
  always_comb begin
    next_stage1 = async;
    next_synced = stage1;
  end

  // Register both stages
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= next_stage1;
      synced <= next_synced;
    end
  end

endmodule // absc_sync

/* src/absc_scan_cells.sv */
`timescale 1ns/100ps
module absc_scan_cells
  import absc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input absc_pkg::absc_tap_s tapPins,
  input absc_pkg::absc_ctrl_s funcCtrl,
  input absc_pkg::absc_obs_s analogObs,
  output absc_pkg::absc_ctrl_s analogCtrl,
  output absc_pkg::absc_obs_s logicObs,
  output logic testDataOut
);
  import absc_pkg::*;

  localparam int N = ABSC_NUM_CELLS;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  absc_tap_s tapSync;

  absc_sync #(
    .WIDTH($bits(absc_tap_s))
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async(tapPins),
    .synced(tapSync)
  );

  //////////////////////////////////////////////////////////////////////////
  // Test clock edge detection

  logic tckLast;
  logic next_tckLast;
  logic tckRise;
  logic tckFall;

  // Edges seen on the synchronised test clock
  always_comb begin
    next_tckLast = tapSync.testClk;
    tckRise = tapSync.testClk && !tckLast;
    tckFall = !tapSync.testClk && tckLast;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tckLast <= 1'b0;
    end else begin
      tckLast <= next_tckLast;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Functional view packed into chain order

  // Pack the functional control bundle into a chain-ordered vector
  function automatic logic [N-1:0] pack_ctrl(input absc_ctrl_s c,
                                             input absc_obs_s o);
    logic [N-1:0] v;
    v = '0;
    v[ABSC_POS_CMP_OFF] = c.comparatorOff;
    v[ABSC_POS_CMP_RES] = o.comparatorResult;
    v[ABSC_POS_CMP_MUX] = c.comparatorUsesConvMux;
    v[ABSC_POS_CMP_BG] = c.comparatorBandgapEn;
    v[ABSC_POS_CONV_CMP] = o.convComparatorResult;
    v[ABSC_POS_GAIN_CLK] = c.gainStageClk;
    v[ABSC_POS_PATH_EN] = c.gainToComparatorPathEn;
    v[ABSC_POS_BG_NEG] = c.convBandgapNegEn;
    v[ABSC_POS_CONV_PWR] = c.convPowerOn;
    v[ABSC_POS_GAIN_PWR] = c.gainStagePowerOn;
    v[ABSC_POS_DAC_LO +: ABSC_DAC_W] = c.dacWord;
    v[ABSC_POS_BYPASS] = c.lowChannelBypassEn;
    v[ABSC_POS_GAIN10] = c.gainTenEn;
    v[ABSC_POS_GAIN20] = c.gainTwentyEn;
    return v;
  endfunction

  // Unpack a chain-ordered vector into the control bundle
  function automatic absc_ctrl_s unpack_ctrl(input logic [N-1:0] v);
    absc_ctrl_s c;
    c.comparatorOff = v[ABSC_POS_CMP_OFF];
    c.comparatorUsesConvMux = v[ABSC_POS_CMP_MUX];
    c.comparatorBandgapEn = v[ABSC_POS_CMP_BG];
    c.gainStageClk = v[ABSC_POS_GAIN_CLK];
    c.gainToComparatorPathEn = v[ABSC_POS_PATH_EN];
    c.convBandgapNegEn = v[ABSC_POS_BG_NEG];
    c.convPowerOn = v[ABSC_POS_CONV_PWR];
    c.gainStagePowerOn = v[ABSC_POS_GAIN_PWR];
    c.dacWord = v[ABSC_POS_DAC_LO +: ABSC_DAC_W];
    c.lowChannelBypassEn = v[ABSC_POS_BYPASS];
    c.gainTenEn = v[ABSC_POS_GAIN10];
    c.gainTwentyEn = v[ABSC_POS_GAIN20];
    return c;
  endfunction

  logic [N-1:0] funcVec;

  // Capture view: controls from logic, results from the analog side
  always_comb begin
    funcVec = pack_ctrl(funcCtrl, analogObs);
  end

  //////////////////////////////////////////////////////////////////////////
  // Shift stage, update stage and serial output

  logic [N-1:0] shiftReg;
  logic [N-1:0] next_shiftReg;
  logic [N-1:0] updReg;
  logic [N-1:0] next_updReg;
  logic next_testDataOut;

  // Capture and shift on rising test clock; update and output on falling
  always_comb begin
    next_shiftReg = shiftReg;
    next_updReg = updReg;
    next_testDataOut = testDataOut;
    if (tckRise) begin
      if (tapSync.captureDr) begin
        next_shiftReg = funcVec;
      end else if (tapSync.shiftDr) begin
        next_shiftReg = {shiftReg[N-2:0], tapSync.testDataIn};
      end
    end
    if (tckFall) begin
      next_testDataOut = shiftReg[N-1];
      if (tapSync.updateDr) begin
        next_updReg = shiftReg;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shiftReg <= '0;
      updReg <= ABSC_UPD_RESET;
      testDataOut <= 1'b0;
    end else begin
      shiftReg <= next_shiftReg;
      updReg <= next_updReg;
      testDataOut <= next_testDataOut;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output muxes: update stage wins only under external test

  absc_ctrl_s ctrlOut;
  absc_ctrl_s next_ctrlOut;
  absc_obs_s obsOut;
  absc_obs_s next_obsOut;

  // Scan-driven controls replace logic ones during external test
  always_comb begin
    if (tapSync.extest) begin
      next_ctrlOut = unpack_ctrl(updReg);
      next_obsOut.comparatorResult = updReg[ABSC_POS_CMP_RES];
      next_obsOut.convComparatorResult = updReg[ABSC_POS_CONV_CMP];
    end else begin
      next_ctrlOut = funcCtrl;
      next_obsOut = analogObs;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrlOut <= ABSC_CTRL_RESET;
      obsOut <= '0;
    end else begin
      ctrlOut <= next_ctrlOut;
      obsOut <= next_obsOut;
    end
  end

  assign analogCtrl = ctrlOut;
  assign logicObs = obsOut;

endmodule // absc_scan_cells

/* bench/absc_scan_cells_monitor.sv */
`timescale 1ns/100ps
module absc_scan_cells_monitor (
  input wire logic clk,
  input wire logic nrst,
  input absc_pkg::absc_tap_s tapPins,
  input absc_pkg::absc_ctrl_s funcCtrl,
  input absc_pkg::absc_obs_s analogObs,
  input absc_pkg::absc_ctrl_s analogCtrl,
  input absc_pkg::absc_obs_s logicObs,
  input wire logic testDataOut
);
  import absc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Functional paths pass through outside external test
  a_ctrl_pass: assert property (
    !tapPins.extest [*6] |-> analogCtrl == $past(funcCtrl))
    else $error("ctrl path");
  a_obs_pass: assert property (
    !tapPins.extest [*6] |-> logicObs == $past(analogObs))
    else $error("obs path");
  // Update stage holds under external test
  a_ctrl_hold: assert property (
    (tapPins.extest && !tapPins.updateDr) [*6] |-> $stable(analogCtrl))
    else $error("ctrl hold");
  a_obs_hold: assert property (
    (tapPins.extest && !tapPins.updateDr) [*6] |-> $stable(logicObs))
    else $error("obs hold");
  // Serial output moves only after a falling test clock
  a_tdo_lag: assert property (
    $fell(tapPins.testClk) |-> $stable(testDataOut) [*2])
    else $error("tdo early");
  a_tdo_high: assert property (
    tapPins.testClk [*4] |-> $stable(testDataOut))
    else $error("tdo high");
  a_tdo_idle: assert property (
    !tapPins.testClk [*8] |-> $stable(testDataOut))
    else $error("tdo idle");
  a_reset_idle: assert property (
    $rose(nrst) |-> analogCtrl == ABSC_CTRL_RESET && logicObs == 2'h0)
    else $error("reset levels");
  // Main scenarios
  c_ext: cover property (tapPins.extest && $changed(analogCtrl));
  c_tdo: cover property ($rose(testDataOut));
  c_res: cover property ($rose(logicObs.comparatorResult));
endmodule // absc_scan_cells_monitor

/* bench/absc_tester.sv */
`timescale 1ns/100ps
module absc_tester (
  input wire logic clk,
  input wire logic testDataOut,
  output absc_pkg::absc_tap_s tapPins
);
  import absc_pkg::*;
  localparam int NW = ABSC_NUM_CELLS;
  localparam logic [NW-1:0] IDLE = 23'h180001;
  initial tapPins = '0;
  // One 800 ns test clock period; returns serial out seen before the rise
  task automatic pulse(output logic q);
    q = testDataOut;
    tapPins.testClk <= 1'b1;
    repeat (4) @(posedge clk);
    tapPins.testClk <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Capture, shift the whole chain far end first, then update
  task automatic scan(input logic [NW-1:0] din, output logic [NW-1:0] dout);
    logic q;
    tapPins.captureDr <= 1'b1;
    pulse(q);
    tapPins.captureDr <= 1'b0;
    tapPins.shiftDr <= 1'b1;
    for (int i = NW - 1; i >= 0; i--) begin
      tapPins.testDataIn <= din[i];
      pulse(dout[i]);
    end
    tapPins.shiftDr <= 1'b0;
    tapPins.testDataIn <= ~din[0]; // Released line shows no stale level
    tapPins.updateDr <= 1'b1;
    pulse(q);
    tapPins.updateDr <= 1'b0;
  endtask
endmodule // absc_tester

/* bench/analog_boundary_scan_cells_test.sv */
`timescale 1ns/100ps
module analog_boundary_scan_cells_test;
  import absc_pkg::*;
  logic clk;
  logic nrst;
  absc_tap_s tapPins;
  absc_ctrl_s funcCtrl;
  absc_ctrl_s c;
  absc_obs_s analogObs;
  absc_ctrl_s analogCtrl;
  absc_obs_s logicObs;
  logic testDataOut;
  localparam int NW = ABSC_NUM_CELLS;
  localparam int CW = $bits(absc_ctrl_s);
  logic [NW-1:0] v;
  logic [NW-1:0] q;
  int nErrors = 0;
  int nTests = 0;
  int cycles = 0;
  absc_scan_cells DUT (.clk(clk), .nrst(nrst), .tapPins(tapPins),
    .funcCtrl(funcCtrl), .analogObs(analogObs), .analogCtrl(analogCtrl),
    .logicObs(logicObs), .testDataOut(testDataOut));
  absc_tester tst (.clk(clk), .testDataOut(testDataOut), .tapPins(tapPins));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      nErrors++;
      endSim();
    end
  end
  // Compare and count
  task automatic cmp(input string nm, input logic [NW-1:0] e, g);
    nTests++;
    if (g !== e) begin
      nErrors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Verdict and stop
  task automatic endSim();
    $display("tests %0d errors %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Chain image taken at capture
  function automatic logic [NW-1:0] capVec(absc_ctrl_s f, absc_obs_s o);
    return {f.gainTwentyEn, f.gainTenEn, f.lowChannelBypassEn,
      f.dacWord, f.gainStagePowerOn, f.convPowerOn, f.convBandgapNegEn,
      f.gainToComparatorPathEn, f.gainStageClk, o.convComparatorResult,
      f.comparatorBandgapEn, f.comparatorUsesConvMux, o.comparatorResult,
      f.comparatorOff};
  endfunction
  // Controls from an update image, in bundle order
  function automatic absc_ctrl_s ctrlOf(logic [NW-1:0] u);
    return {u[0], u[2], u[3], u[5], u[6], u[7], u[8], u[9], u[19:10],
      u[20], u[21], u[22]};
  endfunction
  // Main sequence
  initial begin
    nrst = 1'b0;
    funcCtrl = '0;
    analogObs = '0;
    v = $urandom(69);
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (8) begin
      funcCtrl <= CW'($urandom);
      analogObs <= 2'($urandom);
      repeat (8) @(posedge clk);
      cmp("analogCtrl", NW'(funcCtrl), NW'(analogCtrl));
      cmp("logicObs", NW'(analogObs), NW'(logicObs));
    end
    $display("passthrough done");
    for (int k = 0; k < 5; k++) begin
      v = k == 0 ? tst.IDLE : k == 1 ? {NW{1'b1}} : NW'($urandom);
      c = CW'($urandom);
      funcCtrl <= c;
      analogObs <= k == 0 ? 2'h0 : 2'($urandom);
      @(posedge clk);
      tst.scan(v, q);
      cmp("capture", capVec(funcCtrl, analogObs), q);
      tst.tapPins.extest <= 1'b1;
      funcCtrl <= ~funcCtrl;
      repeat (8) @(posedge clk);
      cmp("extCtrl", NW'(ctrlOf(v)), NW'(analogCtrl));
      cmp("extObs", NW'({v[1], v[4]}), NW'(logicObs));
      tst.tapPins.extest <= 1'b0;
      repeat (8) @(posedge clk);
      cmp("release", NW'(funcCtrl), NW'(analogCtrl));
      $display("scan round %0d done", k);
    end
    endSim();
  end
endmodule // analog_boundary_scan_cells_test
bind absc_scan_cells absc_scan_cells_monitor mon (.clk(clk), .nrst(nrst),
  .tapPins(tapPins), .funcCtrl(funcCtrl), .analogObs(analogObs),
  .analogCtrl(analogCtrl), .logicObs(logicObs), .testDataOut(testDataOut));
